//--- l2cm_bus_model.sv
// System bus side model: takes every write strobe at once and keeps a count and an address sum.
// Assumes one-cycle strobes synchronous to clk.
`timescale 1ns/1ns
module l2cm_bus_model (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        bus_wr_valid,
   input wire logic [31:0] bus_wr_addr,
   output logic [15:0]     wr_cnt,
   output logic [31:0]     wr_sum
);
   // No back-pressure, so no copyback waits here; each strobe is counted at the edge after it is raised.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_cnt <= 16'h0;
         wr_sum <= 32'h0;
      end else if (bus_wr_valid) begin
         wr_cnt <= wr_cnt + 16'h1;
         wr_sum <= wr_sum + bus_wr_addr;
      end
   end
endmodule : l2cm_bus_model

//--- l2cm_cache_ctrl.sv
// Mode and maintenance control of a two-way second-level cache: tag store, lookup,
// allocation policy, global invalidation walk and hardware flush walk.
// Assumes requests, snoops and the register bus are synchronous to clk, and that the
// system bus side accepts every read and write strobe it is given.
//
// Functional notes
// [RQ1] Write-back default; write-through also writes bus.
// [RQ2] Write-through updates mark line exclusive.
// [RQ3] Software never sets write-through once enabled.
// [RQ4] Data-only: only data side allocates.
// [RQ5] Data-only: resident instruction lines still hit.
// [RQ6] Instruction-only: only instruction side allocates.
// [RQ7] Instruction-only: resident data lines still hit.
// [RQ8] Allocation bits act immediately at any time.
// [RQ9] Both bits lock; modified castouts go out.
// [RQ10] Invalidate bit walks and clears every tag.
// [RQ11] Software sets invalidate only while disabled.
// [RQ12] L1 requests held off during invalidation.
// [RQ13] Read-only in-progress flag tracks invalidation.
// [RQ14] Invalidation takes about sixteen thousand cycles.
// [RQ15] Software follows the invalidate sequence order.
// [RQ16] Flush starts on rising edge only.
// [RQ17] Flush walks way 0 then way 1.
// [RQ18] Modified blocks cast out, all tags invalid.
// [RQ19] L1 blocked during flush, snoops still served.
// [RQ20] Hardware clears flush bit when done.
// [RQ21] Flush assist forces data castout allocation.
// [RQ22] Software quiesces before and syncs after flush.
// [RQ23] Sequencer flags readable at any time.
// [RQ24] Enable bit gates lookups; disabled passes through.
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module l2cm_cache_ctrl
   import l2cm_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int IDX_W  = 13,
   parameter int OFF_W  = 5
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              req_valid,
   input  wire logic              req_is_instr,
   input  wire logic              req_is_castout,
   input  wire logic              req_castout_modified,
   input  wire logic              req_coherent,
   input  wire logic [ADDR_W-1:0] req_addr,
   output logic                   req_ready,
   output logic                   resp_valid,
   output logic                   resp_hit,
   output logic                   resp_alloc,
   input  wire logic              snoop_valid,
   input  wire logic              snoop_kill,
   input  wire logic [ADDR_W-1:0] snoop_addr,
   output logic                   snoop_resp_valid,
   output logic                   snoop_hit,
   output logic                   snoop_dirty,
   output logic                   bus_rd_valid,
   output logic [ADDR_W-1:0]      bus_rd_addr,
   output logic                   bus_wr_valid,
   output logic [ADDR_W-1:0]      bus_wr_addr
);

   localparam int TAG_W = ADDR_W - IDX_W - OFF_W;
   localparam int DEPTH = 1 << IDX_W;
   localparam int CNT_W = IDX_W + 1;

   initial begin
      if (TAG_W < 1 || IDX_W < 1 || OFF_W < 0 || IDX_W > 20) begin
         $error("l2cm_cache_ctrl: address split cannot be served");
      end
   end

   // Tag store, one array per field; tag and status indexed by way then set, victim pointer by set.
   logic [TAG_W-1:0] tag_mem [0:1][0:DEPTH-1];
   logic [2:0]       st_mem  [0:1][0:DEPTH-1];
   logic             f_mem   [0:DEPTH-1];

   logic [L2CM_CTRL_W-1:0] second_level_cache_control_reg;
   l2cm_state_t            state_reg;
   l2cm_state_t            state_next;
   logic [CNT_W-1:0]       walk_cnt_reg;
   logic                   wait_reg;
   logic [31:0]            rdata_reg;
   logic                   ready_reg;
   logic                   resp_valid_reg;
   logic                   resp_hit_reg;
   logic                   resp_alloc_reg;
   logic                   snp_valid_reg;
   logic                   snp_hit_reg;
   logic                   snp_dirty_reg;
   logic                   rd_valid_reg;
   logic [ADDR_W-1:0]      rd_addr_reg;
   logic                   wr_valid_reg;
   logic [ADDR_W-1:0]      wr_addr_reg;

   logic cache_enable_bit;
   logic write_through_select;
   logic data_only_alloc;
   logic instruction_only_alloc;
   logic global_invalidate_start;
   logic hardware_flush_trigger;
   logic flush_assist_allocate;
   logic invalidate_in_progress;

   assign cache_enable_bit        = second_level_cache_control_reg[L2CM_EN_BIT];
   assign write_through_select    = second_level_cache_control_reg[L2CM_WT_BIT];
   assign data_only_alloc         = second_level_cache_control_reg[L2CM_DO_BIT];
   assign instruction_only_alloc  = second_level_cache_control_reg[L2CM_IO_BIT];
   assign global_invalidate_start = second_level_cache_control_reg[L2CM_INV_BIT];
   assign hardware_flush_trigger  = second_level_cache_control_reg[L2CM_HWF_BIT];
   assign flush_assist_allocate   = second_level_cache_control_reg[L2CM_FA_BIT];
   assign invalidate_in_progress  = (state_reg == L2CM_INV); // RQ13

   // Register bus decode; a write lands at the edge where waitrequest is seen low.
   logic bus_take;
   logic ctrl_wr;
   logic inv_rise;
   logic hwf_rise;
   logic walk_last;
   assign bus_take  = (avs_read || avs_write) && !wait_reg;
   assign ctrl_wr   = bus_take && avs_write && (avs_address == L2CM_CTRL_OFS) && avs_byteenable[0];
   assign inv_rise  = ctrl_wr && avs_writedata[L2CM_INV_BIT] && !global_invalidate_start; // RQ10
   assign hwf_rise  = ctrl_wr && avs_writedata[L2CM_HWF_BIT] && !hardware_flush_trigger; // RQ16
   assign walk_last = (walk_cnt_reg == {CNT_W{1'b1}});

   // Lookup of the L1 request.
   logic [IDX_W-1:0] r_idx;
   logic [TAG_W-1:0] r_tag;
   logic             r_hit0;
   logic             r_hit1;
   logic             r_hit;
   logic             r_hway;
   logic             r_vway;
   assign r_idx  = req_addr[OFF_W +: IDX_W];
   assign r_tag  = req_addr[ADDR_W-1 -: TAG_W];
   assign r_hit0 = st_mem[0][r_idx][L2CM_ST_V] && (tag_mem[0][r_idx] == r_tag);
   assign r_hit1 = st_mem[1][r_idx][L2CM_ST_V] && (tag_mem[1][r_idx] == r_tag);
   assign r_hit  = r_hit0 || r_hit1;
   assign r_hway = r_hit1;
   assign r_vway = f_mem[r_idx];

   // Lookup of the snoop.
   logic [IDX_W-1:0] s_idx;
   logic [TAG_W-1:0] s_tag;
   logic             s_hit0;
   logic             s_hit1;
   logic             s_hway;
   logic             s_act;
   logic             s_kill;
   assign s_idx  = snoop_addr[OFF_W +: IDX_W];
   assign s_tag  = snoop_addr[ADDR_W-1 -: TAG_W];
   assign s_hit0 = st_mem[0][s_idx][L2CM_ST_V] && (tag_mem[0][s_idx] == s_tag);
   assign s_hit1 = st_mem[1][s_idx][L2CM_ST_V] && (tag_mem[1][s_idx] == s_tag);
   assign s_hway = s_hit1;
   // Snoops run during a flush as well; a disabled cache does not snoop.
   assign s_act  = snoop_valid && cache_enable_bit && (state_reg != L2CM_INV); // RQ19 RQ24
   assign s_kill = s_act && snoop_kill && (s_hit0 || s_hit1);

   // Flush walk entry: the top counter bit is the way, so way 0 is swept first.
   logic             f_way;
   logic [IDX_W-1:0] f_idx;
   logic [2:0]       f_st;
   logic             f_step;
   assign f_way  = walk_cnt_reg[IDX_W];
   assign f_idx  = walk_cnt_reg[IDX_W-1:0]; // RQ17
   assign f_st   = st_mem[f_way][f_idx];
   // A snoop invalidation owns the tag write port, so the flush waits that cycle.
   assign f_step = (state_reg == L2CM_FLUSH) && !s_kill;

   logic req_take;
   assign req_take = req_valid && ready_reg && (state_reg == L2CM_IDLE);

   // Request decision: allocation policy, tag update and bus forwarding.
   logic             alloc_ok;
   logic             d_we;
   logic             d_way;
   logic [2:0]       d_st;
   logic             d_alloc;
   logic             d_hit;
   logic             d_rd;
   logic             d_wr;
   logic [ADDR_W-1:0] d_wr_addr;
   always_comb begin
      alloc_ok  = 1'b0;
      d_we      = 1'b0;
      d_way     = r_hway;
      d_st      = L2CM_ST_INV;
      d_alloc   = 1'b0;
      d_hit     = 1'b0;
      d_rd      = 1'b0;
      d_wr      = 1'b0;
      d_wr_addr = req_addr;
      if (req_is_castout) begin
         // Castouts come from the data side only.
         alloc_ok = !instruction_only_alloc && (req_coherent || flush_assist_allocate); // RQ4 RQ9 RQ21
      end else if (req_is_instr) begin
         alloc_ok = !data_only_alloc; // RQ4 RQ6 RQ9
      end else begin
         alloc_ok = !instruction_only_alloc; // RQ6 RQ9
      end
      if (!cache_enable_bit) begin
         d_rd = !req_is_castout; // RQ24
         d_wr = req_is_castout;
      end else if (r_hit) begin
         d_hit = 1'b1; // RQ5 RQ7
         if (req_is_castout) begin
            d_we = 1'b1;
            d_st = write_through_select ? L2CM_ST_EXC : L2CM_ST_MOD; // RQ2
            d_wr = write_through_select; // RQ1
         end
      end else begin
         d_way = r_vway;
         if (!req_is_castout) begin
            d_rd = 1'b1;
            d_we = alloc_ok;
            d_st = L2CM_ST_EXC;
         end else if (alloc_ok) begin
            d_we = 1'b1;
            d_st = write_through_select ? L2CM_ST_EXC : L2CM_ST_MOD; // RQ2
            d_wr = write_through_select; // RQ1
         end else begin
            d_wr = req_castout_modified; // RQ9
         end
         d_alloc = d_we;
         // A dirty victim is written back unless the bus write slot is already taken.
         if (d_we && !d_wr && st_mem[r_vway][r_idx][L2CM_ST_M] && st_mem[r_vway][r_idx][L2CM_ST_V]) begin
            d_wr      = 1'b1;
            d_wr_addr = {tag_mem[r_vway][r_idx], r_idx, {OFF_W{1'b0}}};
         end
      end
   end

   // Sequencer.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         L2CM_IDLE: begin
            if (inv_rise) begin
               state_next = L2CM_INV; // RQ10
            end else if (hwf_rise) begin
               state_next = L2CM_FLUSH; // RQ16
            end
         end
         L2CM_INV: begin
            if (walk_last) begin
               state_next = L2CM_IDLE; // RQ14
            end
         end
         L2CM_FLUSH: begin
            if (walk_last && f_step) begin
               state_next = L2CM_IDLE;
            end
         end
         default: state_next = L2CM_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= L2CM_IDLE;
         walk_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (state_reg == L2CM_IDLE) begin
            walk_cnt_reg <= '0;
         end else if (state_reg == L2CM_INV || f_step) begin
            walk_cnt_reg <= walk_cnt_reg + 1'b1;
         end
      end
   end

   // Control register; the in-progress bit is never stored, it is the sequencer itself.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         second_level_cache_control_reg <= L2CM_CTRL_RST;
      end else if (ctrl_wr) begin
         second_level_cache_control_reg <= avs_writedata[L2CM_CTRL_W-1:0] & ~(8'h01 << L2CM_IP_BIT); // RQ8
      end else if (state_reg == L2CM_FLUSH && state_next == L2CM_IDLE) begin
         second_level_cache_control_reg[L2CM_HWF_BIT] <= 1'b0; // RQ20
      end
   end

   // Tag store write port: walk, then snoop kill, then flush step, then request.
   always_ff @(posedge clk) begin
      if (state_reg == L2CM_INV) begin
         tag_mem[walk_cnt_reg[IDX_W]][walk_cnt_reg[IDX_W-1:0]] <= '0; // RQ10
         st_mem[walk_cnt_reg[IDX_W]][walk_cnt_reg[IDX_W-1:0]]  <= L2CM_ST_INV;
         f_mem[walk_cnt_reg[IDX_W-1:0]]                         <= 1'b0;
      end else if (s_kill) begin
         st_mem[s_hway][s_idx] <= L2CM_ST_INV;
      end else if (f_step) begin
         st_mem[f_way][f_idx] <= L2CM_ST_INV; // RQ18
      end else if (req_take && d_we) begin
         tag_mem[d_way][r_idx] <= r_tag;
         st_mem[d_way][r_idx]  <= d_st;
         if (d_alloc) begin
            f_mem[r_idx] <= ~r_vway;
         end
      end
   end

   // Request side outputs; L1 traffic is refused while either walk runs.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_reg      <= 1'b0;
         resp_valid_reg <= 1'b0;
         resp_hit_reg   <= 1'b0;
         resp_alloc_reg <= 1'b0;
         rd_valid_reg   <= 1'b0;
         rd_addr_reg    <= '0;
      end else begin
         ready_reg      <= (state_next == L2CM_IDLE); // RQ12 RQ19
         resp_valid_reg <= req_take;
         resp_hit_reg   <= req_take && d_hit;
         resp_alloc_reg <= req_take && d_alloc;
         rd_valid_reg   <= req_take && d_rd;
         rd_addr_reg    <= req_take ? req_addr : rd_addr_reg;
      end
   end

   // System bus write slot, shared by flush castouts and request writes.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_valid_reg <= 1'b0;
         wr_addr_reg  <= '0;
      end else if (f_step && f_st[L2CM_ST_V] && f_st[L2CM_ST_M]) begin
         wr_valid_reg <= 1'b1; // RQ18
         wr_addr_reg  <= {tag_mem[f_way][f_idx], f_idx, {OFF_W{1'b0}}};
      end else if (req_take && d_wr) begin
         wr_valid_reg <= 1'b1;
         wr_addr_reg  <= d_wr_addr;
      end else begin
         wr_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         snp_valid_reg <= 1'b0;
         snp_hit_reg   <= 1'b0;
         snp_dirty_reg <= 1'b0;
      end else begin
         snp_valid_reg <= snoop_valid;
         snp_hit_reg   <= s_act && (s_hit0 || s_hit1); // RQ19
         snp_dirty_reg <= s_act && (s_hit0 || s_hit1) && st_mem[s_hway][s_idx][L2CM_ST_M];
      end
   end

   // Avalon slave: one wait cycle, then the answer; unmapped reads give zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_reg  <= 1'b1;
         rdata_reg <= '0;
      end else begin
         wait_reg  <= !((avs_read || avs_write) && wait_reg);
         rdata_reg <= '0;
         if (avs_address == L2CM_CTRL_OFS) begin
            rdata_reg[L2CM_CTRL_W-1:0]  <= second_level_cache_control_reg;
            rdata_reg[L2CM_IP_BIT]      <= invalidate_in_progress; // RQ23
         end else if (avs_address == L2CM_STAT_OFS) begin
            rdata_reg[CNT_W-1:0]        <= walk_cnt_reg;
            rdata_reg[L2CM_STAT_BUSY_BIT] <= (state_reg != L2CM_IDLE);
         end
      end
   end

   assign avs_readdata     = rdata_reg;
   assign avs_waitrequest  = wait_reg;
   assign req_ready        = ready_reg;
   assign resp_valid       = resp_valid_reg;
   assign resp_hit         = resp_hit_reg;
   assign resp_alloc       = resp_alloc_reg;
   assign snoop_resp_valid = snp_valid_reg;
   assign snoop_hit        = snp_hit_reg;
   assign snoop_dirty      = snp_dirty_reg;
   assign bus_rd_valid     = rd_valid_reg;
   assign bus_rd_addr      = rd_addr_reg;
   assign bus_wr_valid     = wr_valid_reg;
   assign bus_wr_addr      = wr_addr_reg;

endmodule : l2cm_cache_ctrl

//--- l2cm_pkg.sv
// Package for the second-level cache mode and maintenance block.
// Holds the register map, control field positions, tag status codes and sequencer states.
// Assumes a single core clock domain and a 32-bit Avalon-MM register slave.
package l2cm_pkg;

   // Register byte addresses on the Avalon-MM slave.
   localparam logic [3:0] L2CM_CTRL_OFS = 4'h0;
   localparam logic [3:0] L2CM_STAT_OFS = 4'h4;

   // Field positions in second_level_cache_control_reg.
   localparam int L2CM_EN_BIT  = 0;
   localparam int L2CM_WT_BIT  = 1;
   localparam int L2CM_DO_BIT  = 2;
   localparam int L2CM_IO_BIT  = 3;
   localparam int L2CM_INV_BIT = 4;
   localparam int L2CM_IP_BIT  = 5;
   localparam int L2CM_HWF_BIT = 6;
   localparam int L2CM_FA_BIT  = 7;
   localparam int L2CM_CTRL_W  = 8;

   // Field position of the walk busy bit in the status register; the walk index sits below it.
   localparam int L2CM_STAT_BUSY_BIT = 31;

   // The control register clears at power-on reset.
   localparam logic [7:0] L2CM_CTRL_RST = 8'h00;

   // Tag status codes, bits are modified, shared, valid.
   localparam logic [2:0] L2CM_ST_INV = 3'h0;
   localparam logic [2:0] L2CM_ST_EXC = 3'h1;
   localparam logic [2:0] L2CM_ST_MOD = 3'h5;
   localparam int         L2CM_ST_V   = 0;
   localparam int         L2CM_ST_M   = 2;

   // Nominal length of a whole-cache walk in core cycles: two ways of 8192 sets, one entry a cycle.
   localparam int L2CM_WALK_CYCLES = 16384;

   typedef enum logic [1:0] {
      L2CM_IDLE  = 2'b00,
      L2CM_INV   = 2'b01,
      L2CM_FLUSH = 2'b10
   } l2cm_state_t;

endpackage : l2cm_pkg

//--- l2cm_props.sv
// Checker for the cache mode and maintenance block, bound to every instance of it.
// Assumes mode bits change only through register writes, apart from the self-clearing flush bit.
`timescale 1ns/1ns
module l2cm_chk
   import l2cm_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic        req_valid,
   input wire logic        req_is_instr,
   input wire logic        req_is_castout,
   input wire logic        req_castout_modified,
   input wire logic        req_ready,
   input wire logic        resp_valid,
   input wire logic        resp_hit,
   input wire logic        resp_alloc,
   input wire logic        snoop_valid,
   input wire logic        snoop_resp_valid,
   input wire logic        bus_rd_valid,
   input wire logic        bus_wr_valid
);
   logic [7:0] mode_reg;
   logic       take, ctrl_wr, inv_go, en, wt, d_only, i_only, fa;
   assign take = req_valid && req_ready;
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == L2CM_CTRL_OFS && avs_byteenable[0];
   assign inv_go = ctrl_wr && avs_writedata[L2CM_INV_BIT] && !mode_reg[L2CM_INV_BIT];
   assign {i_only, d_only, wt, en} = mode_reg[3:0];
   assign fa = mode_reg[L2CM_FA_BIT];
   // The flush bit copy here goes stale when hardware clears it, so no property relies on it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= 8'h00;
      end else if (ctrl_wr) begin
         mode_reg <= avs_writedata[7:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_RESP_LAT: assert property (take |=> resp_valid)
      else $error("no response after a taken request");
   AST_RESP_CAUSE: assert property (!take |=> !resp_valid)
      else $error("response without a taken request");
   AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for two cycles");
   AST_INV_BLOCK: assert property (inv_go |-> ##2 !req_ready [*6])
      else $error("request accepted during invalidation");
   AST_SNOOP_CAUSE: assert property (snoop_resp_valid |-> $past(snoop_valid))
      else $error("snoop answer without snoop");
   AST_BUSRD_CAUSE: assert property (bus_rd_valid |-> $past(take))
      else $error("bus read without request");
   AST_WT_FWD: assert property (take && req_is_castout && (wt || !en) |=> bus_wr_valid)
      else $error("castout not written to the bus");
   AST_DIS_MISS: assert property (take && !en |=> !resp_hit && !resp_alloc)
      else $error("disabled cache used its tags");
   AST_ALLOC_SRC: assert property (take && en && ((d_only && req_is_instr) || (i_only && !req_is_instr))
      |=> !resp_alloc)
      else $error("allocation from a barred source");
   AST_LOCK_FWD: assert property (take && en && d_only && i_only && req_is_castout && req_castout_modified
      |=> bus_wr_valid)
      else $error("locked modified castout not forwarded");
   AST_FA_ALLOC: assert property (take && en && fa && !i_only && req_is_castout |=> resp_hit || resp_alloc)
      else $error("flush assist castout not allocated");
   cover property (inv_go);
   cover property (take && en && d_only && i_only);
   cover property (snoop_resp_valid && !req_ready);
endmodule : l2cm_chk
bind l2cm_cache_ctrl l2cm_chk u_chk (.*);

//--- l2cm_tb.sv
// Testbench for the cache mode and maintenance block: registers, mode table, invalidate and flush.
// Assumes a small index width so that each walk lasts a few cycles.
`timescale 1ns/1ns
module tb;
   import l2cm_pkg::*;
   localparam int IDX_W = 3;
   localparam int WALK  = 2 ** (IDX_W + 1);
   typedef struct packed {
      logic [7:0]  c;
      logic [2:0]  k;
      logic [11:0] a;
      logic [3:0]  e;
   } l2cm_row_t;
   logic        clk, rst, avs_read, avs_write, req_valid, req_is_instr, req_is_castout, req_coherent;
   logic        req_castout_modified, req_ready, resp_valid, resp_hit, resp_alloc, avs_waitrequest;
   logic        snoop_valid, snoop_kill, snoop_resp_valid, snoop_hit, snoop_dirty, bus_rd_valid, bus_wr_valid;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, req_addr, snoop_addr, bus_rd_addr, bus_wr_addr;
   logic [31:0] wr_sum, s0, base, q;
   logic [15:0] wr_cnt, c0;
   logic [7:0]  lfsr, cur;
   logic [3:0]  exp_q[$];
   logic [2:0]  sr;
   int          failures, n_checks, i, cyc;
   time         t0;
   // Kind is {instruction, castout, coherent}; expected is {hit, alloc, bus read, bus write}.
   l2cm_row_t rows [17] = '{{8'h01, 3'h3, 12'h100, 4'h4}, {8'h01, 3'h0, 12'h100, 4'h8},
      {8'h01, 3'h3, 12'h100, 4'h8}, {8'h01, 3'h2, 12'h120, 4'h1},
      {8'h01, 3'h4, 12'h140, 4'h6}, {8'h05, 3'h4, 12'h140, 4'h8},
      {8'h05, 3'h4, 12'h160, 4'h2}, {8'h05, 3'h3, 12'h180, 4'h4},
      {8'h09, 3'h0, 12'h180, 4'h8}, {8'h09, 3'h3, 12'h1A0, 4'h1},
      {8'h09, 3'h4, 12'h160, 4'h6}, {8'h0D, 3'h4, 12'h1C0, 4'h2},
      {8'h0D, 3'h3, 12'h1E0, 4'h1}, {8'h0D, 3'h0, 12'h100, 4'h8},
      {8'h81, 3'h2, 12'h120, 4'h4}, {8'h00, 3'h0, 12'h100, 4'h2},
      {8'h00, 3'h3, 12'h100, 4'h1}};
   l2cm_cache_ctrl #(.IDX_W(IDX_W)) uut (.*);
   l2cm_bus_model u_bus (.*);
   always #10 clk = ~clk;
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic hung(input logic bad);
      if (bad) begin
         check(32'h0, 32'h1);
         test_done();
      end
   endtask : hung
   task automatic done(input string s);
      $display("test %0s finished", s);
   endtask : done
   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~d;
      hung(n >= 20);
   endtask : avs
   task automatic wr(input logic [31:0] d);
      logic [31:0] r;
      avs(1'b1, L2CM_CTRL_OFS, d, 4'hF, r);
   endtask : wr
   task automatic l1(input logic [2:0] k, input logic [31:0] a, input logic [3:0] e);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      {req_is_instr, req_is_castout, req_coherent} <= k;
      req_castout_modified <= k[1];
      req_addr <= a;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      exp_q.push_back(e);
      req_valid <= 1'b0;
      req_addr <= ~a;
      hung(n >= 40);
   endtask : l1
   task automatic snoop(input logic [31:0] a, input logic k, output logic [2:0] r);
      @(posedge clk);
      snoop_valid <= 1'b1;
      snoop_kill <= k;
      snoop_addr <= a;
      @(posedge clk);
      snoop_valid <= 1'b0;
      snoop_kill <= 1'b0;
      snoop_addr <= ~a;
      @(posedge clk);
      r = {snoop_resp_valid, snoop_hit, snoop_dirty};
   endtask : snoop
   task automatic wait_clear(input int b);
      int n;
      n = 0;
      do begin
         avs(1'b0, L2CM_CTRL_OFS, 32'h0, 4'hF, q);
         n++;
      end while (q[b] !== 1'b0 && n < 20);
      cyc = int'(($time - t0) / 20);
      hung(q[b] !== 1'b0);
   endtask : wait_clear
   task automatic invalidate();
      wr(32'h10);
      t0 = $time;
      avs(1'b0, L2CM_CTRL_OFS, 32'h0, 4'hF, q);
      check(q, 32'h30);
      avs(1'b0, L2CM_STAT_OFS, 32'h0, 4'hF, q);
      check({31'h0, q[L2CM_STAT_BUSY_BIT]}, 32'h1);
      wait_clear(L2CM_IP_BIT);
      check({31'h0, cyc >= WALK - 2 && cyc <= WALK + 7}, 32'h1);
      wr(32'h00);
   endtask : invalidate
   always @(posedge clk) begin
      if (resp_valid === 1'b1) begin
         hung(exp_q.size() == 0);
         check({28'h0, resp_hit, resp_alloc, bus_rd_valid, bus_wr_valid}, {28'h0, exp_q.pop_front()});
      end
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {avs_read, avs_write, req_valid, req_is_instr, req_is_castout, req_castout_modified} = '0;
      {req_coherent, snoop_valid, snoop_kill, avs_address, avs_byteenable, avs_writedata} = '0;
      {req_addr, snoop_addr, failures, n_checks} = '0;
      lfsr = 8'h60;
      cur = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      avs(1'b0, L2CM_CTRL_OFS, 32'h0, 4'hF, q);
      check(q, {24'h0, L2CM_CTRL_RST});
      avs(1'b1, L2CM_CTRL_OFS, 32'h1, 4'h2, q);
      wr(32'h20);
      avs(1'b0, L2CM_CTRL_OFS, 32'h0, 4'hF, q);
      check(q, 32'h0);
      avs(1'b0, 4'h8, 32'h0, 4'hF, q);
      check(q, 32'h0);
      done("registers");
      invalidate();
      base = {12'h0, lfsr, 12'h0};
      for (i = 0; i < 17; i++) begin
         if (rows[i].c !== cur) begin
            wr({24'h0, rows[i].c});
         end
         cur = rows[i].c;
         lfsr = lfsr_next(lfsr);
         l1(rows[i].k, base + {20'h0, rows[i].a} + {27'h0, lfsr[4:0]}, rows[i].e);
      end
      done("modes");
      invalidate();
      wr(32'h02);
      wr(32'h03);
      l1(3'h3, base + 32'h100, 4'h5);
      snoop(base + 32'h100, 1'b0, sr);
      check({29'h0, sr}, 32'h6);
      wr(32'h00);
      done("write_through");
      invalidate();
      wr(32'h01);
      l1(3'h3, base + 32'h100, 4'h4);
      l1(3'h3, base + 32'h200, 4'h4);
      l1(3'h4, base + 32'h140, 4'h6);
      snoop(base + 32'h100, 1'b0, sr);
      check({29'h0, sr}, 32'h7);
      s0 = wr_sum;
      c0 = wr_cnt;
      wr(32'h41);
      t0 = $time;
      snoop(base + 32'h140, 1'b0, sr);
      check({31'h0, sr[2]}, 32'h1);
      wr(32'h41);
      wait_clear(L2CM_HWF_BIT);
      check({31'h0, cyc <= WALK + 7}, 32'h1);
      check(q, 32'h01);
      check({16'h0, wr_cnt - c0}, 32'h2);
      check(wr_sum - s0, base + base + 32'h300);
      l1(3'h4, base + 32'h140, 4'h6);
      snoop(base + 32'h140, 1'b1, sr);
      check({29'h0, sr}, 32'h6);
      snoop(base + 32'h140, 1'b0, sr);
      check({29'h0, sr}, 32'h4);
      repeat (3) @(posedge clk);
      done("flush");
      check(exp_q.size(), 32'h0);
      test_done();
   end
endmodule : tb
